// ### include/lppb_regs.svh
// Register offsets, field positions, reset values and timing counts for the LED port block
`ifndef LPPB_REGS_SVH
`define LPPB_REGS_SVH

// ==========================================
// Register map
`define LPPB_NUM_PORTS 4
`define LPPB_COMMON_DUTY_ADDR 8'h45
`define LPPB_DUTY_BASE_ADDR 8'h50
`define LPPB_DUTY_LAST_ADDR 8'h53
`define LPPB_CFG_BASE_ADDR 8'h54
`define LPPB_CFG_LAST_ADDR 8'h57
`define LPPB_GROUP_MASK 8'hfc

// ==========================================
// Field layout of the configuration register
`define LPPB_CFG_SEL_BIT 5
`define LPPB_CFG_PERIOD_MSB 4
`define LPPB_CFG_PERIOD_LSB 2
`define LPPB_CFG_ONTIME_MSB 1
`define LPPB_CFG_ONTIME_LSB 0

// ==========================================
// Reset values and codes
`define LPPB_DUTY_RESET 8'h00
`define LPPB_CFG_RESET 6'h00
`define LPPB_DUTY_FULL 8'hff
`define LPPB_PERIOD_NONE 3'h0
`define LPPB_PERIOD_LAST 3'h5
`define LPPB_PERIOD_SHIFT 4'h7
`define LPPB_READ_IDLE 8'h00

// ==========================================
// Timing
`define LPPB_CLK_MHZ 50
`define LPPB_STEP_NS 1000
`define LPPB_STEP_CYCLES ((`LPPB_STEP_NS * `LPPB_CLK_MHZ + 999) / 1000)
`define LPPB_TICK_MS 1
`define LPPB_MS_CYCLES (`LPPB_TICK_MS * `LPPB_CLK_MHZ * 1000)

`endif

// ### include/lppb_pkg.sv
// Types shared by the LED port block
package lppb_pkg;

  // ==========================================
  // Per-port configuration
  typedef struct packed {
    logic common_sel;
    logic [2:0] blink_period;
    logic [1:0] on_time;
  } lppb_cfg_t;

  // ==========================================
  // Register access request from the serial port engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lppb_req_t;

endpackage

// ### logic/lppb_port.sv
// One LED port: duty modulation gated by the blink window
`include "lppb_regs.svh"
module lppb_port
  import lppb_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire lppb_cfg_t cfg,
  input wire logic [7:0] duty_own,
  input wire logic [7:0] duty_common,
  input wire logic [7:0] pwm_step,
  input wire logic [11:0] ms_count,
  output logic led_sink_oe
);

  // ==========================================
  // Blink window
  function automatic logic blink_window(input logic [2:0] period, input logic [1:0] on_time,
                                        input logic [11:0] ms);
    logic [3:0] k;
    logic [12:0] span;
    logic [12:0] phase;
    logic [12:0] limit;
    k = 4'h0;
    span = 13'h0000;
    phase = 13'h0000;
    limit = 13'h0000;
    if (period == `LPPB_PERIOD_NONE || period > `LPPB_PERIOD_LAST) begin
      blink_window = 1'b1;
    end else begin
      k = {1'b0, period} + `LPPB_PERIOD_SHIFT;
      span = 13'h0001 << k;
      phase = {1'b0, ms} & (span - 13'h0001);
      limit = span >> ({2'b00, on_time} + 4'h1);
      blink_window = phase < limit;
    end
  endfunction

  logic [7:0] duty;
  logic pwm_on;
  logic next_led_sink_oe;

  always_comb begin
    duty = cfg.common_sel ? duty_common : duty_own;
    pwm_on = (duty == `LPPB_DUTY_FULL) || (pwm_step < duty);
    next_led_sink_oe = pwm_on && blink_window(cfg.blink_period, cfg.on_time, ms_count);
  end

  // ==========================================
  // Output drive
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      led_sink_oe <= 1'b0;
    end else begin
      led_sink_oe <= next_led_sink_oe;
    end
  end

endmodule

// ### logic/lppb_top.sv
// LED port duty and blink block with its register file
// Overview of operation
// - Four per-port duty registers at consecutive addresses, first port lowest.
// - Duty n from 1 to 254 lights the LED n of 256 steps.
// - Duty all ones keeps the LED on continuously.
// - Per-port duty registers reset to zero, LED off.
// - Four per-port configuration registers at consecutive addresses, same port order.
// - Select bit picks own duty register at zero, common duty at one.
// - Period code zero no blink; codes one to five give 256 to 4096 ms.
// - On-time code gives 50, 25, 12.5 or 6.25 percent of period.
// - Common duty register shares the encoding and resets to zero.
`include "lppb_regs.svh"
module lppb_top
  import lppb_pkg::*;
#(
  parameter int NUM_PORTS = `LPPB_NUM_PORTS,
  parameter int STEP_CYCLES = `LPPB_STEP_CYCLES,
  parameter int MS_CYCLES = `LPPB_MS_CYCLES
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire lppb_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  output logic [NUM_PORTS-1:0] led_port_sink_oe
);

  localparam int STEP_W = $clog2(STEP_CYCLES + 1);
  localparam int MS_W = $clog2(MS_CYCLES + 1);

  // ==========================================
  // Address decode
  function automatic logic in_group(input logic [7:0] addr, input logic [7:0] base);
    in_group = (addr & `LPPB_GROUP_MASK) == base;
  endfunction

  function automatic logic [5:0] cfg_bits(input lppb_cfg_t c);
    cfg_bits = {c.common_sel, c.blink_period, c.on_time};
  endfunction

  logic [7:0] duty [NUM_PORTS];
  lppb_cfg_t cfg [NUM_PORTS];
  logic [7:0] common_duty;
  logic [1:0] idx;

  assign idx = req.addr[1:0];

  // ==========================================
  // Register writes
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        duty[i] <= `LPPB_DUTY_RESET;
      end
    end else if (req.wr && in_group(req.addr, `LPPB_DUTY_BASE_ADDR)) begin
      duty[idx] <= req.wdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NUM_PORTS; i++) begin
        cfg[i] <= `LPPB_CFG_RESET;
      end
    end else if (req.wr && in_group(req.addr, `LPPB_CFG_BASE_ADDR)) begin
      cfg[idx] <= req.wdata[`LPPB_CFG_SEL_BIT:`LPPB_CFG_ONTIME_LSB];
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      common_duty <= `LPPB_DUTY_RESET;
    end else if (req.wr && req.addr == `LPPB_COMMON_DUTY_ADDR) begin
      common_duty <= req.wdata;
    end
  end

  // ==========================================
  // Register reads
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata <= `LPPB_READ_IDLE;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.rd;
      if (req.rd) begin
        if (in_group(req.addr, `LPPB_DUTY_BASE_ADDR)) begin
          rdata <= duty[idx];
        end else if (in_group(req.addr, `LPPB_CFG_BASE_ADDR)) begin
          rdata <= {2'b00, cfg_bits(cfg[idx])};
        end else if (req.addr == `LPPB_COMMON_DUTY_ADDR) begin
          rdata <= common_duty;
        end else begin
          rdata <= `LPPB_READ_IDLE;
        end
      end
    end
  end

  // ==========================================
  // Modulation step timebase
  logic [STEP_W-1:0] step_div;
  logic [7:0] pwm_step;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      step_div <= '0;
      pwm_step <= 8'h00;
    end else if (step_div == STEP_W'(STEP_CYCLES - 1)) begin
      step_div <= '0;
      pwm_step <= pwm_step + 8'h01;
    end else begin
      step_div <= step_div + STEP_W'(1);
    end
  end

  // ==========================================
  // Millisecond timebase for blinking
  logic [MS_W-1:0] ms_div;
  logic [11:0] ms_count;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ms_div <= '0;
      ms_count <= 12'h000;
    end else if (ms_div == MS_W'(MS_CYCLES - 1)) begin
      ms_div <= '0;
      ms_count <= ms_count + 12'h001;
    end else begin
      ms_div <= ms_div + MS_W'(1);
    end
  end

  // ==========================================
  // Port channels
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    lppb_port u_port (
      .clk(clk),
      .rstn(rstn),
      .cfg(cfg[p]),
      .duty_own(duty[p]),
      .duty_common(common_duty),
      .pwm_step(pwm_step),
      .ms_count(ms_count),
      .led_sink_oe(led_port_sink_oe[p])
    );
  end

endmodule

// ### bench/lppb_led.sv
// LED observer counting lit clocks per port
module lppb_led (
  input wire logic clk,
  input wire logic clr,
  input wire logic [3:0] sink_oe,
  output integer cnt [4]
);
  timeunit 1ns;
  timeprecision 1ns;
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i] <= clr ? 0 : cnt[i] + {31'd0, sink_oe[i]};
    end
  end
endmodule

// ### bench/lppb_chk_sva.sv
// Register port and LED checks
module lppb_chk
  import lppb_pkg::*;
#(
  parameter int NUM_PORTS = 4
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire lppb_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  input wire logic [NUM_PORTS-1:0] led_port_sink_oe
);
  logic wrote;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wrote <= 1'b0;
    end else if (req.wr) begin
      wrote <= 1'b1;
    end
  end
  property p_ans; req.rd |=> rvalid; endproperty
  a_ans: assert property (p_ans) else $error("no rvalid");
  property p_one; !req.rd |=> !rvalid; endproperty
  a_one: assert property (p_one) else $error("extra rvalid");
  property p_hold; !rvalid |-> $stable(rdata); endproperty
  a_hold: assert property (p_hold) else $error("rdata moved");
  property p_gap; req.rd && req.addr > 8'h57 |=> rdata == 8'h00; endproperty
  a_gap: assert property (p_gap) else $error("bad gap");
  property p_top; req.rd && req.addr[7:2] == 6'h15 |=> rdata[7:6] == 2'b00; endproperty
  a_top: assert property (p_top) else $error("bad top");
  property p_duty;
    req.wr && req.addr == 8'h50 ##1 req.rd && req.addr == 8'h50 |=> rdata == $past(req.wdata, 2);
  endproperty
  a_duty: assert property (p_duty) else $error("bad duty");
  property p_sel;
    req.wr && req.addr == 8'h54 ##1 req.rd && req.addr == 8'h54 |=> rdata == ($past(req.wdata, 2) & 8'h3f);
  endproperty
  a_sel: assert property (p_sel) else $error("bad cfg");
  property p_off; !wrote |-> led_port_sink_oe == '0; endproperty
  a_off: assert property (p_off) else $error("lit early");
endmodule
bind lppb_top lppb_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
  .rvalid(rvalid), .led_port_sink_oe(led_port_sink_oe));

// ### bench/testbench.sv
// Self-checking bench for the LED port block
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; $display("unexpected %0t bad", $time); end end
module testbench
  import lppb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic rstn = 0;
  logic clr = 1;
  lppb_req_t req = '0;
  logic [7:0] rdata;
  logic rvalid;
  logic [3:0] oe;
  integer cnt [4];
  int n_fail = 0;
  int total_checks = 0;
  lppb_top #(.STEP_CYCLES(1), .MS_CYCLES(4)) i_dut (.clk(clk), .rstn(rstn), .req(req), .rdata(rdata),
    .rvalid(rvalid), .led_port_sink_oe(oe));
  lppb_led i_led (.clk(clk), .clr(clr), .sink_oe(oe), .cnt(cnt));
  initial forever #10 clk = ~clk;
  task op(input logic w, r, input logic [7:0] a, d);
    @(posedge clk);
    #1 req = '{w, r, a, d};
  endtask
  task rd(input logic [7:0] a, e);
    op(0, 1, a, 8'h00);
    op(0, 0, 8'h00, 8'h00);
    `CHK({rvalid, rdata}, {1'b1, e})
  endtask
  task meas(input int n, input int e [4]);
    op(0, 0, 8'h00, 8'h00);
    clr = 1;
    repeat (3) @(posedge clk);
    #1 clr = 0;
    repeat (n) @(posedge clk);
    #1;
    for (int i = 0; i < 4; i++) `CHK(cnt[i], e[i])
  endtask
  task t_regs;
    meas(300, '{0, 0, 0, 0});
    rd(8'h45, 8'h00);
    for (int a = 'h50; a < 'h58; a++) begin
      rd(8'(a), 8'h00);
      op(1, 0, 8'(a), 8'(a ^ 'hff));
      rd(8'(a), 8'(a < 'h54 ? a ^ 'hff : (a ^ 'hff) & 'h3f));
    end
    op(1, 0, 8'h46, 8'hff);
    rd(8'h46, 8'h00);
    rd(8'h58, 8'h00);
  endtask
  task t_pwm;
    for (int a = 'h54; a < 'h58; a++) op(1, 0, 8'(a), 8'h00);
    op(1, 0, 8'h50, 8'h01);
    op(1, 0, 8'h51, 8'h80);
    op(1, 0, 8'h52, 8'hfe);
    op(1, 0, 8'h53, 8'hff);
    meas(256, '{1, 128, 254, 256});
    op(1, 0, 8'h45, 8'h40);
    op(1, 0, 8'h54, 8'h20);
    meas(256, '{64, 128, 254, 256});
  endtask
  task t_blink;
    int n;
    int k;
    op(1, 0, 8'h45, 8'h80);
    for (int a = 'h50; a < 'h53; a++) op(1, 0, 8'(a), 8'hff);
    for (int c = 1; c < 8; c++) begin
      for (int p = 0; p < 3; p++) op(1, 0, 8'('h54 + p), 8'(c * 4 + p + 1));
      op(1, 0, 8'h57, 8'('h20 + c * 4));
      n = c < 6 ? 512 << c : 1024;
      k = c < 6 ? 1 : 0;
      meas(n, '{n >> (2 * k), n >> (3 * k), n >> (4 * k), n >> (k + 1)});
    end
  endtask
  task give_verdict;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    t_regs;
    t_pwm;
    t_blink;
    give_verdict;
  end
endmodule
